// >>> common/gdms_pkg.sv
// Constants and carrier types of the gateway device message block
package gdms_pkg;

  // ********************
  // Timing
  // ********************
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD = 19_200;
  localparam int BAUD_DIV = (CLK_HZ + BAUD / 2) / BAUD;
  // Three and a half characters of eleven bits at the default rate
  localparam int T35_US = 2005;
  localparam int CYC_T35 = T35_US * (CLK_HZ / 1_000_000);
  // One unit of the host inactivity timeout
  localparam int MS_US = 1000;
  localparam int CYC_MS = MS_US * (CLK_HZ / 1_000_000);

  // ********************
  // Register map and reset values
  // ********************
  localparam logic [15:0] REG_MSG = 16'h0008;
  localparam logic [15:0] REG_ADDR = 16'h0014;
  localparam logic [15:0] REG_TMO = 16'h0015;
  localparam logic [15:0] REG_HLF = 16'h0016;
  localparam int CFG_N = 3;
  localparam int RD_MAX = 3;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [15:0] TMO_RST = 16'h0000;
  localparam logic HLF_RST = 1'b1;

  // ********************
  // Protocol codes
  // ********************
  localparam logic [7:0] FC_RD = 8'h03;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VAL = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ********************
  // Message codes
  // ********************
  localparam logic [7:0] MC_NONE = 8'h00;
  localparam logic [7:0] MC_UNK = 8'h01;
  localparam logic [7:0] MC_RADIO = 8'h35;
  localparam logic [7:0] MC_HOST = 8'h36;
  localparam logic [7:0] MC_OFF = 8'hFE;
  localparam logic [7:0] MD_SYNC = 8'h80;
  localparam logic [7:0] MD_ERR = 8'h01;
  localparam logic [7:0] MD_NONE = 8'h00;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } gdms_msg_type;

  typedef struct packed {
    logic present;
    logic synced;
    logic unk_evt;
    logic [7:0] unk_data;
    logic radio_to;
    logic msg_off;
    logic msg_clr;
    logic survey;
    logic [15:0] survey_data;
  } gdms_node_type;

  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_EXE = 2'b01,
    ST_TX = 2'b10
  } gdms_state_type;

endpackage : gdms_pkg

// >>> src/gdms_uart.sv
// Character framer: one start, eight data, no parity, one stop bit
`timescale 1ns/100ps
`default_nettype none
module gdms_uart import gdms_pkg::*; #(
  parameter int DIV = BAUD_DIV // Clocks per bit
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic rx_pin, // Serial receive line
  output logic rx_vld, // Pulse: byte received
  output logic [7:0] rx_byte, // Received byte
  output logic rx_ferr, // Pulse: stop bit missing
  input wire logic tx_go, // Pulse: send tx_byte
  input wire logic [7:0] tx_byte, // Byte to send
  output logic tx_busy, // Sending
  output logic tx_pin // Serial transmit line
);

  logic [1:0] sy_q;
  logic rxs, rbusy_q, rvld_q, rferr_q;
  logic [15:0] rcnt_q, tcnt_q;
  logic [3:0] rbit_q, tbit_q;
  logic [7:0] rsh_q;
  logic [9:0] tsh_q;
  logic tbusy_q, tx_q;

  // ********************
  // Receiver
  // ********************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sy_q <= 2'b11;
    end else begin
      sy_q <= {sy_q[0], rx_pin};
    end
  end
  assign rxs = sy_q[1];

  // Sampling mid-bit; the start bit is checked and shifted in, then pushed out; the byte is complete after nine shifts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rbusy_q <= 1'b0;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rsh_q <= 8'h00;
      rvld_q <= 1'b0;
      rferr_q <= 1'b0;
    end else begin
      rvld_q <= 1'b0;
      rferr_q <= 1'b0;
      if (!rbusy_q) begin
        if (!rxs) begin
          rbusy_q <= 1'b1;
          rcnt_q <= 16'(DIV / 2);
          rbit_q <= 4'h0;
        end
      end else if (rcnt_q != 16'h0000) begin
        rcnt_q <= rcnt_q - 16'h0001;
      end else begin
        rcnt_q <= 16'(DIV - 1);
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && rxs) begin
          rbusy_q <= 1'b0; // Glitch, not a start bit
        end else if (rbit_q == 4'h9) begin
          rbusy_q <= 1'b0;
          rvld_q <= rxs;
          rferr_q <= !rxs;
        end else begin
          rsh_q <= {rxs, rsh_q[7:1]};
        end
      end
    end
  end
  assign rx_vld = rvld_q;
  assign rx_ferr = rferr_q;
  assign rx_byte = rsh_q;

  // ********************
  // Transmitter
  // ********************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tbusy_q <= 1'b0;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 10'h3FF;
      tx_q <= 1'b1;
    end else if (!tbusy_q) begin
      if (tx_go) begin
        tbusy_q <= 1'b1;
        tsh_q <= {1'b1, tx_byte, 1'b0};
        tbit_q <= 4'h0;
        tcnt_q <= 16'(DIV - 1);
        tx_q <= 1'b0;
      end
    end else if (tcnt_q != 16'h0000) begin
      tcnt_q <= tcnt_q - 16'h0001;
    end else if (tbit_q == 4'h9) begin
      tbusy_q <= 1'b0;
      tx_q <= 1'b1;
    end else begin
      tcnt_q <= 16'(DIV - 1);
      tbit_q <= tbit_q + 4'h1;
      tsh_q <= {1'b1, tsh_q[9:1]};
      tx_q <= tsh_q[1];
    end
  end
  assign tx_busy = tbusy_q;
  assign tx_pin = tx_q;

endmodule : gdms_uart
`default_nettype wire

// >>> src/gdms_gateway.sv
// Serial slave of the gateway with its device message register
// Contract
// - Characters are 1 start, 8 data, no parity, 1 stop bit at 19.2k.
// - Every exchange on the serial port uses RTU framing with CRC.
// - Only function codes 3, 6 and 16 are accepted; others get an exception.
// - Slave address resets to 1 and is writable.
// - Inactivity timeout resets to zero; zero disables detection.
// - Register 8 shows messages, or survey results in survey mode.
// - A message stays until its condition changes or a higher one arises.
// - A numerically larger message code takes precedence.
// - Message code sits in bits 15:8, data byte in bits 7:0.
// - Synchronized node with no fault reads 0x0080.
// - Zero means no device present; a present node that is not synchronized and has no fault also reads zero here.
// - Code 01 with any data marks a good-checksum unknown command.
// - Code 35 data 01 marks a radio polling or heartbeat dropout.
// - Timeout codes carry data bit 0 set while the error exists.
// - Code 36 data 01 marks serial inactivity beyond the timeout.
// - Code FE shows messages cleared or disabled by the control command; only msg_off shows FE here, msg_clr just drops the unknown-command report.
// - Host link failure sets the code and commands outputs to defaults.
// - Per-node enable flag; when clear outputs stay unchanged.
`timescale 1ns/100ps
`default_nettype none
module gdms_gateway import gdms_pkg::*; #(
  parameter int T35_CYC = CYC_T35, // Silence that ends a frame
  parameter int MS_CYC = CYC_MS, // Clocks per timeout unit
  parameter int BUF_N = 16, // Largest frame held, in bytes
  parameter int BIT_CYC = BAUD_DIV // Clocks per serial bit
) (
  input wire logic clk, // 20 MHz system clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic rx_pin, // Serial receive line
  output logic tx_pin, // Serial transmit line
  output logic tx_oe, // Line driver enable
  input wire gdms_node_type node, // Node condition inputs
  output gdms_msg_type msg, // Device message register
  output logic host_to, // Host link failure level
  output logic node_dflt // Pulse: drive node outputs to defaults
);

  localparam int LW = $clog2(BUF_N + 3);

  gdms_state_type st_q;
  logic rx_vld, rx_ferr, tx_busy, tx_go, go_q, tx_oe_q;
  logic [7:0] rx_byte, tx_byte, fc, exc;
  logic [7:0] rbuf_q [BUF_N];
  logic [7:0] tbuf_q [BUF_N];
  logic [LW-1:0] rlen_q, tlen_q, tptr_q;
  logic [15:0] crc_q, tcrc_q, sil_q, s_a, q_a;
  logic bad_q, frm_end, fr_ok, rng_ok, len_bad;
  logic [7:0] addr_q;
  logic [15:0] tmo_q;
  logic hlf_q;
  logic [CFG_N-1:0] wen;
  logic [15:0] wval [CFG_N];
  logic [15:0] ms_q, tcnt_q;
  logic host_d, host_to_q, node_dflt_q;
  logic unk_q;
  logic [7:0] unk_data_q;
  gdms_msg_type msg_q;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic [15:0] rd_reg(input logic [15:0] idx, input gdms_msg_type m,
                                         input logic [7:0] a, input logic [15:0] t,
                                         input logic h);
    case (idx)
      REG_MSG: rd_reg = m;
      REG_ADDR: rd_reg = {8'h00, a};
      REG_TMO: rd_reg = t;
      REG_HLF: rd_reg = {15'h0000, h};
      default: rd_reg = 16'h0000;
    endcase
  endfunction : rd_reg

  gdms_uart #(.DIV(BIT_CYC)) u_uart (
    .clk(clk),
    .nrst(nrst),
    .rx_pin(rx_pin),
    .rx_vld(rx_vld),
    .rx_byte(rx_byte),
    .rx_ferr(rx_ferr),
    .tx_go(tx_go),
    .tx_byte(tx_byte),
    .tx_busy(tx_busy),
    .tx_pin(tx_pin)
  );

  // ********************
  // Frame reception
  // ********************
  assign frm_end = (st_q == ST_RX) && (rlen_q != '0) && (sil_q == 16'(T35_CYC - 1));
  // The residue over a whole frame including its CRC is zero
  assign fr_ok = frm_end && !bad_q && (crc_q == 16'h0000) && (rlen_q >= LW'(4))
                 && (rbuf_q[0] == addr_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rlen_q <= '0;
      crc_q <= CRC_INIT;
      bad_q <= 1'b0;
      sil_q <= 16'h0000;
    end else if (st_q != ST_RX || (frm_end && !fr_ok)) begin
      rlen_q <= '0;
      crc_q <= CRC_INIT;
      bad_q <= 1'b0;
      sil_q <= 16'h0000;
    end else if (rx_vld || rx_ferr) begin
      sil_q <= 16'h0000;
      if (rx_ferr || rlen_q >= LW'(BUF_N)) begin
        bad_q <= 1'b1; // Whole frame dropped, no partial decode
      end else begin
        rlen_q <= rlen_q + LW'(1);
        crc_q <= crc_step(crc_q, rx_byte);
      end
    end else if (sil_q != 16'(T35_CYC - 1)) begin
      sil_q <= sil_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (st_q == ST_RX && rx_vld && rlen_q < LW'(BUF_N)) begin
      rbuf_q[rlen_q[$clog2(BUF_N)-1:0]] <= rx_byte;
    end
  end

  // ********************
  // Request decode
  // ********************
  assign fc = rbuf_q[1];
  assign s_a = {rbuf_q[2], rbuf_q[3]};
  assign q_a = {rbuf_q[4], rbuf_q[5]};
  assign rng_ok = (fc == FC_RD && s_a == REG_MSG && q_a == 16'h0001)
                  || ({1'b0, s_a} >= {1'b0, REG_ADDR}
                  && {1'b0, s_a} + {1'b0, q_a} <= {1'b0, REG_HLF} + 17'h00001);
  assign len_bad = (fc == FC_WRN) ? (rlen_q != LW'(9 + 2 * int'(q_a[1:0]))
                   || rbuf_q[6] != {5'h00, q_a[1:0], 1'b0}) : (rlen_q != LW'(8));

  always_comb begin
    exc = 8'h00;
    if (fc != FC_RD && fc != FC_WR1 && fc != FC_WRN) begin
      exc = EX_FUNC;
    end else if (fc == FC_WR1) begin
      if (len_bad) begin
        exc = EX_VAL;
      end else if (s_a < REG_ADDR || s_a > REG_HLF) begin
        exc = EX_ADDR; // Message register is read only
      end
    end else if (q_a == 16'h0000 || q_a > 16'(RD_MAX) || len_bad) begin
      exc = EX_VAL;
    end else if (!rng_ok) begin
      exc = EX_ADDR;
    end
  end

  always_comb begin
    for (int j = 0; j < CFG_N; j++) begin
      wen[j] = 1'b0;
      wval[j] = q_a;
      for (int k = 0; k < RD_MAX; k++) begin
        if (st_q == ST_EXE && exc == 8'h00 && s_a + 16'(k) == REG_ADDR + 16'(j)) begin
          if (fc == FC_WR1 && k == 0) begin
            wen[j] = 1'b1;
          end else if (fc == FC_WRN && 16'(k) < q_a) begin
            wen[j] = 1'b1;
            wval[j] = {rbuf_q[7 + 2 * k], rbuf_q[8 + 2 * k]};
          end
        end
      end
    end
  end

  // ********************
  // Configuration registers
  // ********************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_q <= ADDR_RST;
      tmo_q <= TMO_RST;
      hlf_q <= HLF_RST;
    end else begin
      if (wen[0]) begin
        addr_q <= wval[0][7:0];
      end
      if (wen[1]) begin
        tmo_q <= wval[1];
      end
      if (wen[2]) begin
        hlf_q <= wval[2][0];
      end
    end
  end

  // ********************
  // Sequencer and reply
  // ********************
  assign tx_go = (st_q == ST_TX) && !tx_busy && !go_q && (tptr_q < tlen_q + LW'(2));
  assign tx_byte = (tptr_q < tlen_q) ? tbuf_q[tptr_q[$clog2(BUF_N)-1:0]]
                 : (tptr_q == tlen_q) ? tcrc_q[7:0] : tcrc_q[15:8];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_RX;
      tlen_q <= '0;
      tptr_q <= '0;
      go_q <= 1'b0;
      tcrc_q <= CRC_INIT;
      tx_oe_q <= 1'b0;
    end else begin
      tx_oe_q <= (st_q == ST_TX);
      case (st_q)
        ST_RX: begin
          if (fr_ok) begin
            st_q <= ST_EXE;
          end
        end
        ST_EXE: begin
          st_q <= ST_TX;
          tptr_q <= '0;
          go_q <= 1'b0;
          tcrc_q <= CRC_INIT;
          if (exc != 8'h00) begin
            tlen_q <= LW'(3);
          end else if (fc == FC_RD) begin
            tlen_q <= LW'(3 + 2 * int'(q_a[1:0]));
          end else begin
            tlen_q <= LW'(6);
          end
        end
        ST_TX: begin
          go_q <= tx_go; // Busy shows one clock after the start pulse
          if (tx_go) begin
            tptr_q <= tptr_q + LW'(1);
            if (tptr_q < tlen_q) begin
              tcrc_q <= crc_step(tcrc_q, tx_byte);
            end
          end else if (!go_q && !tx_busy) begin
            st_q <= ST_RX;
          end
        end
        default: st_q <= ST_RX;
      endcase
    end
  end
  assign tx_oe = tx_oe_q;

  always_ff @(posedge clk) begin
    if (st_q == ST_EXE) begin
      tbuf_q[0] <= addr_q;
      tbuf_q[1] <= (exc != 8'h00) ? (fc | EXC_FLAG) : fc;
      if (exc != 8'h00) begin
        tbuf_q[2] <= exc;
      end else if (fc == FC_RD) begin
        tbuf_q[2] <= {5'h00, q_a[1:0], 1'b0};
        for (int k = 0; k < RD_MAX; k++) begin
          {tbuf_q[3 + 2 * k], tbuf_q[4 + 2 * k]} <= rd_reg(s_a + 16'(k), msg_q, addr_q,
                                                          tmo_q, hlf_q);
        end
      end else begin
        for (int k = 2; k < 6; k++) begin
          tbuf_q[k] <= rbuf_q[k];
        end
      end
    end
  end

  // ********************
  // Host inactivity
  // ********************
  assign host_d = (tmo_q != 16'h0000) && (tcnt_q >= tmo_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ms_q <= 16'h0000;
      tcnt_q <= 16'h0000;
      host_to_q <= 1'b0;
      node_dflt_q <= 1'b0;
    end else begin
      if (tmo_q == 16'h0000 || fr_ok || ms_q == 16'(MS_CYC - 1)) begin
        ms_q <= 16'h0000;
      end else begin
        ms_q <= ms_q + 16'h0001;
      end
      if (tmo_q == 16'h0000 || fr_ok) begin
        tcnt_q <= 16'h0000;
      end else if (ms_q == 16'(MS_CYC - 1) && tcnt_q != 16'hFFFF) begin
        tcnt_q <= tcnt_q + 16'h0001;
      end
      host_to_q <= host_d;
      node_dflt_q <= host_d && !host_to_q && hlf_q;
    end
  end
  assign host_to = host_to_q;
  assign node_dflt = node_dflt_q;

  // ********************
  // Device message register
  // ********************
  // Unknown-command report is held until cleared, so it is not resent
  always_ff @(posedge clk) begin
    if (!nrst) begin
      unk_q <= 1'b0;
      unk_data_q <= 8'h00;
    end else if (node.unk_evt) begin
      unk_q <= 1'b1;
      unk_data_q <= node.unk_data;
    end else if (node.msg_clr) begin
      unk_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      msg_q <= {MC_NONE, MD_NONE};
    end else if (node.survey) begin
      msg_q <= node.survey_data;
    end else if (!node.present) begin
      msg_q <= {MC_NONE, MD_NONE};
    end else if (node.msg_off) begin
      msg_q <= {MC_OFF, MD_NONE};
    end else if (host_to_q) begin
      msg_q <= {MC_HOST, MD_ERR};
    end else if (node.radio_to) begin
      msg_q <= {MC_RADIO, MD_ERR};
    end else if (unk_q) begin
      msg_q <= {MC_UNK, unk_data_q};
    end else if (node.synced) begin
      msg_q <= {MC_NONE, MD_SYNC};
    end else begin
      msg_q <= {MC_NONE, MD_NONE};
    end
  end
  assign msg = msg_q;

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_sync_value: assert property (node.present && node.synced && !node.survey && !node.msg_off
    && !host_to_q && !node.radio_to && !unk_q |=> msg_q == 16'h0080)
    else $error("synchronized node does not read 0x0080");
  a_absent_zero: assert property (!node.present && !node.survey |=> msg_q == 16'h0000)
    else $error("absent node does not read zero");
  a_host_code: assert property (host_to_q && node.present && !node.survey && !node.msg_off
    |=> msg_q.code == MC_HOST && msg_q.data[0])
    else $error("host timeout code missing");
  a_radio_code: assert property (node.radio_to && node.present && !node.survey
    && !node.msg_off && !host_to_q |=> msg_q == 16'h3501)
    else $error("radio timeout code missing");
  a_off_prio: assert property (node.msg_off && node.present && !node.survey
    |=> msg_q.code == MC_OFF)
    else $error("disabled code not shown");
  a_unk_hold: assert property (node.unk_evt ##1 (!node.msg_clr && !node.unk_evt)[*2]
    |-> unk_q)
    else $error("unknown message lost before clear");
  a_tmo_off: assert property (tmo_q == 16'h0000 ##1 tmo_q == 16'h0000 |-> !host_to_q)
    else $error("timeout flagged while disabled");
  a_timer_restart: assert property (fr_ok |=> tcnt_q == 16'h0000 ##1 !host_to_q)
    else $error("timer not restarted by good frame");
  a_dflt_gate: assert property ($rose(host_to_q) |-> node_dflt_q == $past(hlf_q))
    else $error("default command not gated by enable flag");
  a_fc_except: assert property (st_q == ST_EXE && fc != FC_RD && fc != FC_WR1 && fc != FC_WRN
    |=> tbuf_q[1] == (fc | EXC_FLAG) && tbuf_q[2] == EX_FUNC && tlen_q == LW'(3))
    else $error("unsupported function not refused");

endmodule : gdms_gateway
`default_nettype wire

// >>> sim/gdms_host.sv
// Host side model: serial master that frames requests and collects replies
`timescale 1ns/100ps
`default_nettype none
module gdms_host #(
  parameter int BIT = 1042 // Clocks per bit
) (
  input wire logic clk, // System clock
  output logic rx_pin, // Line into the gateway
  input wire logic tx_pin, // Line from the gateway
  input wire logic tx_oe // Gateway driver enable
);
  // ********
  // Framing
  // ********
  // Biased line idles high between frames
  initial rx_pin = 1'b1;

  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc

  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    logic [9:0] f;
    c = crc(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    @(negedge clk);
    foreach (q[i]) begin
      f = {1'b1, q[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        rx_pin = f[b];
        repeat (BIT) @(negedge clk);
      end
    end
  endtask : send

  // A short queue tells the caller that a byte was missing or badly framed
  task automatic get(input int n, output logic [7:0] q[$]);
    int w;
    logic [7:0] d;
    q = {};
    for (int k = 0; k < n; k++) begin
      // The reply may wait out the whole frame silence before its first start bit
      for (w = 0; tx_pin !== 1'b0 && w < 40 * BIT; w++) @(negedge clk);
      if (w >= 40 * BIT) return;
      repeat (BIT / 2) @(negedge clk);
      for (int b = 0; b < 8; b++) begin
        repeat (BIT) @(negedge clk);
        d[b] = tx_pin;
      end
      repeat (BIT) @(negedge clk);
      if (tx_pin !== 1'b1 || tx_oe !== 1'b1) return;
      q.push_back(d);
    end
  endtask : get
endmodule : gdms_host
`default_nettype wire

// >>> sim/tb.sv
// Self-checking testbench of the gateway serial slave and message register
`timescale 1ns/100ps
`default_nettype none
module tb import gdms_pkg::*;;
  logic clk;
  logic nrst;
  logic rx_pin;
  logic tx_pin;
  logic tx_oe;
  logic host_to;
  logic node_dflt;
  gdms_node_type node;
  gdms_msg_type msg;
  int miscompares;
  int compares;
  int dflt_n;

  // Short bit time, silence and timeout unit keep the run brief; silence spans 2.5 characters
  localparam int BT = 16;
  gdms_gateway #(.T35_CYC(400), .MS_CYC(50), .BUF_N(16), .BIT_CYC(BT)) gdms_gateway_inst (
    .clk(clk), .nrst(nrst), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe),
    .node(node), .msg(msg), .host_to(host_to), .node_dflt(node_dflt));
  gdms_host #(.BIT(BT)) gdms_host_inst (
    .clk(clk), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe));

  // ********
  // Helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) if (node_dflt === 1'b1) dflt_n++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic settle(input logic [15:0] exp);
    repeat (2) @(negedge clk);
    chk(msg, exp, "message register");
  endtask : settle

  task automatic xfer(input logic [7:0] rq[$], input logic [7:0] ex[$]);
    logic [7:0] rs[$];
    logic [15:0] c;
    c = gdms_host_inst.crc(ex);
    ex.push_back(c[7:0]);
    ex.push_back(c[15:8]);
    gdms_host_inst.send(rq);
    gdms_host_inst.get(ex.size(), rs);
    chk(16'(rs.size()), 16'(ex.size()), "reply length");
    foreach (ex[i]) if (i < rs.size()) chk({8'h00, rs[i]}, {8'h00, ex[i]}, "reply byte");
    // Driver must let go once the last stop bit is over
    repeat (BT) @(negedge clk);
    chk({15'h0000, tx_oe}, 16'h0000, "driver enable after reply");
  endtask : xfer

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // ********
  // Scenarios
  // ********
  task automatic t_msgs();
    node.present = 1'b1;
    node.synced = 1'b1;
    settle(16'h0080);
    node.radio_to = 1'b1;
    settle(16'h3501);
    node.unk_data = 8'hA5;
    node.unk_evt = 1'b1;
    @(negedge clk) node.unk_evt = 1'b0;
    settle(16'h3501);
    node.radio_to = 1'b0;
    settle(16'h01A5);
    node.msg_off = 1'b1;
    settle(16'hFE00);
    node.msg_off = 1'b0;
    settle(16'h01A5);
    node.msg_clr = 1'b1;
    @(negedge clk) node.msg_clr = 1'b0;
    settle(16'h0080);
    node.survey_data = 16'h1234;
    node.survey = 1'b1;
    settle(16'h1234);
    node.survey = 1'b0;
    node.present = 1'b0;
    settle(16'h0000);
    node.present = 1'b1;
    settle(16'h0080);
  endtask : t_msgs

  task automatic t_timeout();
    chk({15'h0000, host_to}, 16'h0000, "no timeout by default");
    xfer('{8'h01, 8'h06, 8'h00, 8'h15, 8'h00, 8'h01},
         '{8'h01, 8'h06, 8'h00, 8'h15, 8'h00, 8'h01});
    chk({15'h0000, host_to}, 16'h0001, "link failure level");
    chk(msg, 16'h3601, "link failure message");
    chk(16'(dflt_n), 16'h0001, "default outputs command");
    // Timeout stays at one unit but the enable flag is cleared; the frame restarts the timer
    xfer('{8'h01, 8'h10, 8'h00, 8'h15, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00},
         '{8'h01, 8'h10, 8'h00, 8'h15, 8'h00, 8'h02});
    chk({15'h0000, host_to}, 16'h0001, "link failure after restart");
    chk(16'(dflt_n), 16'h0001, "default command while disabled");
    xfer('{8'h01, 8'h10, 8'h00, 8'h15, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00},
         '{8'h01, 8'h10, 8'h00, 8'h15, 8'h00, 8'h01});
    chk({15'h0000, host_to}, 16'h0000, "failure cleared, timer off");
    chk(msg, 16'h0080, "message after recovery");
  endtask : t_timeout

  initial begin
    nrst = 1'b0;
    node = '0;
    repeat (4) @(negedge clk);
    chk(msg, 16'h0000, "message in reset");
    chk({14'h0000, tx_oe, tx_pin}, 16'h0001, "line idle in reset");
    nrst = 1'b1;
    t_msgs();
    xfer('{8'h01, 8'h03, 8'h00, 8'h08, 8'h00, 8'h01},
         '{8'h01, 8'h03, 8'h02, 8'h00, 8'h80});
    xfer('{8'h01, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h01});
    xfer('{8'h01, 8'h06, 8'h00, 8'h08, 8'h00, 8'h01}, '{8'h01, 8'h86, 8'h02});
    t_timeout();
    wrap_up();
  end

  // Six exchanges take about 18k clocks; the limit leaves twice that
  initial begin
    repeat (40_000) @(posedge clk);
    miscompares++;
    $display("ERROR %0t run did not finish", $time);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
